// ==== flash_program_erase_timing.v ====
// Contract
// - a single word or byte program lasts 30 ticks.
// - first element of a block program lasts 25 ticks.
// - each element 1 to 63 of a block lasts 18 ticks.
// - a 6 tick end wait follows the last block element.
// - durations are fixed; mass erase 10593, segment erase 4819 ticks.
`timescale 1ns/1ps
`default_nettype none
`include "flash_timing_defs.vh"

module flash_program_erase_timing (
  input wire clk_i,
  input wire rst_i,
  input wire tick_i,
  input wire start_i,
  input wire [2:0] cmd_i,
  input wire data_valid_i,
  output wire data_ready_o,
  output reg busy_o,
  output reg program_o,
  output reg erase_o,
  output reg mass_o,
  output reg [5:0] element_o,
  output reg element_done_o,
  output reg done_o
);

  // ==========================================================
  // states
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_WORD = 3'h1;
  localparam [2:0] S_BLK = 3'h2;
  localparam [2:0] S_BWAIT = 3'h3;
  localparam [2:0] S_END = 3'h4;
  localparam [2:0] S_ERASE = 3'h5;

  // ==========================================================
  // tick synchroniser: the tick comes from another clock source
  reg tick_s1;
  reg tick_s2;
  reg tick_s3;
  wire tick_edge;

  always @(posedge clk_i) begin
    if (rst_i) begin
      tick_s1 <= 1'b0;
      tick_s2 <= 1'b0;
      tick_s3 <= 1'b0;
    end else begin
      tick_s1 <= tick_i;
      tick_s2 <= tick_s1;
      tick_s3 <= tick_s2;
    end
  end

  // one period counted per rising edge of the tick clock
  assign tick_edge = tick_s2 & ~tick_s3;

  // ==========================================================
  // sequencer
  reg [2:0] state;
  reg [13:0] count;
  reg [2:0] next_state;
  reg [13:0] next_count;
  reg [5:0] next_element;
  reg next_busy;
  reg next_program;
  reg next_erase;
  reg next_mass;
  reg next_element_done;
  reg next_done;
  wire count_end;
  wire last_element;

  assign count_end = tick_edge && (count == 14'h0001);
  assign last_element = (element_o == `BLOCK_LAST_INDEX);
  // next block element is taken only between elements
  assign data_ready_o = (state == S_BWAIT);

  // ==========================================================
  // next-state decode
  always @* begin
    next_state = state;
    next_count = count;
    next_element = element_o;
    next_busy = busy_o;
    next_program = program_o;
    next_erase = erase_o;
    next_mass = mass_o;
    next_element_done = 1'b0;
    next_done = 1'b0;
    // the count runs down on every tick and rests at zero
    if (tick_edge && count != 14'h0000)
      next_count = count - 14'h0001;
    case (state)
      S_IDLE: begin
        // commands only start here, so a busy sequencer ignores them
        if (start_i) begin
          next_element = 6'h00;
          case (cmd_i)
            `CMD_WORD: begin
              next_state = S_WORD;
              next_count = `SINGLE_PROGRAM_DURATION;
              next_busy = 1'b1;
              next_program = 1'b1;
            end
            `CMD_BLOCK: begin
              next_state = S_BLK;
              next_count = `BLOCK_FIRST_ELEMENT_DURATION;
              next_busy = 1'b1;
              next_program = 1'b1;
            end
            `CMD_SEG_ERASE: begin
              next_state = S_ERASE;
              next_count = `SEGMENT_ERASE_DURATION;
              next_busy = 1'b1;
              next_erase = 1'b1;
            end
            `CMD_MASS_ERASE: begin
              next_state = S_ERASE;
              next_count = `WHOLE_ARRAY_ERASE_DURATION;
              next_busy = 1'b1;
              next_erase = 1'b1;
              next_mass = 1'b1;
            end
            default: next_state = S_IDLE;
          endcase
        end
      end
      S_WORD: begin
        if (count_end) begin
          next_state = S_IDLE;
          next_busy = 1'b0;
          next_program = 1'b0;
          next_done = 1'b1;
        end
      end
      S_ERASE: begin
        // mass and segment erase share this state; only the count and mass_o differ
        if (count_end) begin
          next_state = S_IDLE;
          next_busy = 1'b0;
          next_erase = 1'b0;
          next_mass = 1'b0;
          next_done = 1'b1;
        end
      end
      S_BLK: begin
        // program stays high across element boundaries
        if (count_end) begin
          next_element_done = 1'b1;
          if (last_element) begin
            next_state = S_END;
            next_count = `BLOCK_END_WAIT_DURATION;
            next_program = 1'b0;
          end else begin
            next_state = S_BWAIT;
          end
        end
      end
      S_BWAIT: begin
        // program stays applied while waiting; limitation: software
        // must bound the wait to keep cumulative time legal
        if (data_valid_i) begin
          next_state = S_BLK;
          next_element = element_o + 6'h01;
          next_count = `BLOCK_NEXT_ELEMENT_DURATION;
        end
      end
      S_END: begin
        // end wait keeps busy high with program already low
        if (count_end) begin
          next_state = S_IDLE;
          next_busy = 1'b0;
          next_done = 1'b1;
        end
      end
      default: begin
        // an unused code falls back to a clean idle with busy, program, erase and mass low
        next_state = S_IDLE;
        next_busy = 1'b0;
        next_program = 1'b0;
        next_erase = 1'b0;
        next_mass = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // state and output registers
  // outputs other than data_ready_o come straight from flip-flops so the array sees no glitches
  always @(posedge clk_i) begin
    if (rst_i) begin
      state <= S_IDLE;
      count <= 14'h0000;
      busy_o <= 1'b0;
      program_o <= 1'b0;
      erase_o <= 1'b0;
      mass_o <= 1'b0;
      element_o <= 6'h00;
      element_done_o <= 1'b0;
      done_o <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      busy_o <= next_busy;
      program_o <= next_program;
      erase_o <= next_erase;
      mass_o <= next_mass;
      element_o <= next_element;
      element_done_o <= next_element_done;
      done_o <= next_done;
    end
  end

endmodule // flash_program_erase_timing
`default_nettype wire

// ==== flash_timing_defs.vh ====
`ifndef FLASH_TIMING_DEFS_VH
`define FLASH_TIMING_DEFS_VH

// ==========================================================
// command encodings
`define CMD_NONE 3'h0
`define CMD_WORD 3'h1
`define CMD_BLOCK 3'h2
`define CMD_SEG_ERASE 3'h3
`define CMD_MASS_ERASE 3'h4

// ==========================================================
// tick rate limits in kHz (kept by the clock source)
`define TIMING_GEN_CLOCK_FREQ_MIN_KHZ 9'h101
`define TIMING_GEN_CLOCK_FREQ_MAX_KHZ 9'h1dc

// ==========================================================
// durations in timing-generator ticks
`define SINGLE_PROGRAM_DURATION 14'h001e
`define BLOCK_FIRST_ELEMENT_DURATION 14'h0019
`define BLOCK_NEXT_ELEMENT_DURATION 14'h0012
`define BLOCK_END_WAIT_DURATION 14'h0006
`define WHOLE_ARRAY_ERASE_DURATION 14'h2961
`define SEGMENT_ERASE_DURATION 14'h12d3
`define BLOCK_LAST_INDEX 6'h3f

// ==========================================================
// limits kept by software, in ms
`define CUMULATIVE_PROGRAM_LIMIT_MS 4'ha
`define CUMULATIVE_WHOLE_ERASE_MINIMUM_MS 5'h14

`endif

// ==== flash_timing_props.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====
// sequencer checks
module flash_timing_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [2:0] cmd_i,
  input wire logic data_ready_o,
  input wire logic busy_o,
  input wire logic program_o,
  input wire logic erase_o,
  input wire logic mass_o,
  input wire logic [5:0] element_o,
  input wire logic done_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_take(logic [2:0] c);
    start_i && !busy_o && cmd_i == c;
  endsequence
  property p_word; s_take(3'h1) |=> program_o && !erase_o; endproperty
  a_word: assert property (p_word) else $error("word");
  property p_blk; s_take(3'h2) |=> program_o && element_o == 6'h00; endproperty
  a_blk: assert property (p_blk) else $error("block");
  property p_mass; s_take(3'h4) |=> erase_o && mass_o; endproperty
  a_mass: assert property (p_mass) else $error("mass");
  property p_hold; busy_o |=> busy_o || done_o; endproperty
  a_hold: assert property (p_hold) else $error("busy");
  property p_done; done_o |-> !busy_o ##1 !done_o; endproperty
  a_done: assert property (p_done) else $error("done");
  property p_keep; busy_o ##1 busy_o |-> $stable(mass_o); endproperty
  a_keep: assert property (p_keep) else $error("mode");
  property p_rdy; data_ready_o |-> program_o && element_o != 6'h3f; endproperty
  a_rdy: assert property (p_rdy) else $error("ready");
  property p_end; busy_o && !program_o && !erase_o |-> element_o == 6'h3f;
  endproperty
  a_end: assert property (p_end) else $error("end");
endmodule // flash_timing_props
bind flash_program_erase_timing flash_timing_props u_props (.*);
`default_nettype wire

// ==== flash_data_source.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====
// tick sped up to one per 4 clocks so long erases fit the run
module flash_data_source (
  input wire logic clk_i,
  input wire logic slow_i,
  output logic tick_o,
  output logic data_valid_o
);
  logic [1:0] cnt = 2'h0;
  always @(posedge clk_i) begin
    cnt <= cnt + 2'h1;
  end
  // one tick period stands for one timing-generator period
  assign tick_o = cnt[1];
  assign data_valid_o = !slow_i || cnt == 2'h3;
endmodule // flash_data_source
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
// ====
// scenarios
module tb_top;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic start_i = 1'b0;
  logic slow = 1'b0;
  logic [2:0] cmd_i = 3'h0;
  wire tick_i, data_valid_i, data_ready_o, busy_o, program_o, erase_o, mass_o;
  wire element_done_o, done_o;
  wire [5:0] element_o;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  always #5 clk_i = ~clk_i;
  flash_data_source src (.clk_i(clk_i), .slow_i(slow), .tick_o(tick_i),
    .data_valid_o(data_valid_i));
  flash_program_erase_timing dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick_i),
    .start_i(start_i),
    .cmd_i(cmd_i),
    .data_valid_i(data_valid_i),
    .data_ready_o(data_ready_o),
    .busy_o(busy_o),
    .program_o(program_o),
    .erase_o(erase_o),
    .mass_o(mass_o),
    .element_o(element_o),
    .element_done_o(element_done_o),
    .done_o(done_o)
  );
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task stop_test;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 90000) begin
      num_errors++;
      stop_test;
    end
  end
  // a second start while busy must be ignored; run time counted in clocks
  task automatic run(input logic [2:0] c, input int n, slack, ne);
    int t;
    int k;
    t = 2;
    k = 0;
    start_i = 1'b1;
    cmd_i = c;
    @(posedge clk_i);
    #1 cmd_i = c ^ 3'h5;
    @(posedge clk_i);
    #1 start_i = 1'b0;
    while (done_o !== 1'b1 && t < 50000) begin
      @(posedge clk_i);
      #1 t++;
      k += element_done_o;
    end
    check(t >= 4 * n - 3 && t <= 4 * n + 1 + slack, 1'b1);
    check(k, ne);
    @(posedge clk_i);
    #1 check(done_o, 1'b0);
  endtask
  task t_idle_bad;
    start_i = 1'b1;
    cmd_i = 3'h7;
    @(posedge clk_i);
    #1 cmd_i = 3'h0;
    @(posedge clk_i);
    #1 start_i = 1'b0;
    check(busy_o, 1'b0);
  endtask
  // one block program per block between erases keeps the total low
  task t_block;
    slow = 1'b1;
    run(3'h2, 25 + 63 * 18 + 6, 640, 64);
    slow = 1'b0;
  endtask
  initial begin
    repeat (3) @(posedge clk_i);
    #1 rst_i = 1'b0;
    run(3'h1, 30, 0, 0);
    t_idle_bad();
    run(3'h3, 4819, 0, 0);
    t_block();
    // one mass erase already lasts past the required total
    run(3'h4, 10593, 0, 0);
    stop_test();
  end
endmodule // tb_top
`default_nettype wire
